// ### logic/fdsm_classify.sv
// Turns an event into its category bits: at most one range bit plus any slot bits
`timescale 1ns/1ps
`default_nettype none
module fdsm_classify
  import fdsm_pkg::*;
(
  fdsm_cls_if.cls cif
);
  logic [1:0] alloc;
  logic alloc_ok;
  logic [4:0] range_idx;
  logic [MAP_W-1:0] range_bits;
  logic [MAP_W-1:0] slot_bits;

  // Allocation group, gap 701..799 and above 999 belong to no range
  assign alloc = (cif.evt_number <= SENS_MAX) ? 2'h0 :
                 (cif.evt_number <= ELEC_MAX) ? 2'h1 :
                 (cif.evt_number <= CONF_MAX) ? 2'h2 : 2'h3;
  assign alloc_ok = (cif.evt_number <= CONF_MAX) ||
                    ((cif.evt_number >= PROC_MIN) && (cif.evt_number <= PROC_MAX));
  // Severity group sets the nibble, allocation the bit inside it
  assign range_idx = 5'(RANGE_TOP_BIT) - {1'b0, cif.evt_native, alloc};
  assign range_bits = alloc_ok ? (32'h0000_0001 << range_idx) : 32'h0000_0000;

  always_comb begin
    slot_bits = 32'h0000_0000;
    for (int k = 1; k <= NUM_SLOT; k++) begin
      slot_bits[k] = cif.slot_en[k] && (cif.slot_num[k] == cif.evt_number);
    end
  end

  assign cif.cat_bits = range_bits | slot_bits;
endmodule // fdsm_classify
`default_nettype wire

// ### logic/fdsm_cls_if.sv
// Carrier between the mapper top and its range classifier
`timescale 1ns/1ps
`default_nettype none
interface fdsm_cls_if;
  import fdsm_pkg::*;
  logic [1:0] evt_native;
  logic [NUM_W-1:0] evt_number;
  logic [NUM_W-1:0] slot_num [1:NUM_SLOT];
  logic [NUM_SLOT:1] slot_en;
  logic [MAP_W-1:0] cat_bits;
  modport cls (input evt_native, input evt_number, input slot_num, input slot_en,
    output cat_bits);
  modport top (output evt_native, output evt_number, output slot_num, output slot_en,
    input cat_bits);
endinterface
`default_nettype wire

// ### logic/fdsm_pkg.sv
// Constants and parameter layout of the field diagnostic status mapper
// Operation
// - Events rank by native status: failure highest, check high, offspec and maintenance low.
// - Numbers 0-199 sensor, 200-399 electronics, 400-700 configuration, 800-999 process.
// - Each status owns a 32-bit map; bits 31 to 16 select the sixteen ranges.
// - Reset maps hold bits 31-28, 27-24, 23-20 and 19-16 respectively; rest zero.
// - A map bit moves its whole diagnostic range to or from that status.
// - Map bits 15 to 1 are slots binding one chosen event to a status.
// - An enabled slot whose bit is set in a map records its event there.
// - An event in a range assigned to no status sends nothing to the host.
// - Map changes leave active entries alone; new mapping applies on next occurrence.
// - Events go onto the bus only when their status priority is 2 to 15.
// - Priority 1 events are displayed locally but never sent on the bus.
// - Priority 0 is the reset value; such events are neither shown, sent nor made active, but OUT_NUMBER still captures them.
// - Each of the four statuses has its own independently writable priority.
// - A set broadcast mask bit blocks bus sending, the event is still displayed.
package fdsm_pkg;
  localparam int NUM_STAT = 4;
  localparam int NUM_SLOT = 15;
  localparam int NUM_W = 10;
  localparam int MAP_W = 32;
  localparam int PRI_W = 4;
  localparam int SEL_W = 5;
  // Status indices, highest weighting first
  localparam logic [1:0] ST_FAIL = 2'h0;
  localparam logic [1:0] ST_CHECK = 2'h1;
  localparam logic [1:0] ST_OFFSPEC = 2'h2;
  localparam logic [1:0] ST_MAINT = 2'h3;
  // Allocation bounds
  localparam logic [NUM_W-1:0] SENS_MAX = 10'd199;
  localparam logic [NUM_W-1:0] ELEC_MAX = 10'd399;
  localparam logic [NUM_W-1:0] CONF_MAX = 10'd700;
  localparam logic [NUM_W-1:0] PROC_MIN = 10'd800;
  localparam logic [NUM_W-1:0] PROC_MAX = 10'd999;
  localparam int RANGE_TOP_BIT = 31;
  localparam int RANGE_LOW_BIT = 16;
  // Map reset values
  localparam logic [MAP_W-1:0] FAIL_MAP_RST = 32'hF000_0000;
  localparam logic [MAP_W-1:0] CHECK_MAP_RST = 32'h0F00_0000;
  localparam logic [MAP_W-1:0] OFFSPEC_MAP_RST = 32'h00F0_0000;
  localparam logic [MAP_W-1:0] MAINT_MAP_RST = 32'h000F_0000;
  localparam logic [PRI_W-1:0] PRI_RST = 4'h0;
  localparam logic [PRI_W-1:0] PRI_SHOW = 4'h1;
  localparam logic [PRI_W-1:0] PRI_SEND_MIN = 4'h2;
  localparam logic [MAP_W-1:0] MASK_RST = 32'h0000_0000;
  // Parameter select codes
  localparam logic [SEL_W-1:0] SEL_FAIL_MAP = 5'h00;
  localparam logic [SEL_W-1:0] SEL_CHECK_MAP = 5'h01;
  localparam logic [SEL_W-1:0] SEL_OFFSPEC_MAP = 5'h02;
  localparam logic [SEL_W-1:0] SEL_MAINT_MAP = 5'h03;
  localparam logic [SEL_W-1:0] SEL_FAIL_PRI = 5'h04;
  localparam logic [SEL_W-1:0] SEL_CHECK_PRI = 5'h05;
  localparam logic [SEL_W-1:0] SEL_OFFSPEC_PRI = 5'h06;
  localparam logic [SEL_W-1:0] SEL_MAINT_PRI = 5'h07;
  localparam logic [SEL_W-1:0] SEL_BCAST_MASK = 5'h08;
  localparam logic [SEL_W-1:0] SEL_SLOT_FIRST = 5'h11;
  localparam logic [SEL_W-1:0] SEL_SLOT_LAST = 5'h1F;
  // Slot word layout
  localparam int SLOT_EN_BIT = 15;
endpackage

// ### logic/fdsm_top.sv
// Field diagnostic status mapper: maps, priorities, mask and event routing
`timescale 1ns/1ps
`default_nettype none
module fdsm_top
  import fdsm_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic OUT_OF_SERVICE_MODE,
  input wire logic PARAM_WR,
  input wire logic [SEL_W-1:0] PARAM_SEL,
  input wire logic [MAP_W-1:0] PARAM_WDATA,
  input wire logic EVT_VALID,
  input wire logic [1:0] EVT_NATIVE,
  input wire logic [NUM_W-1:0] EVT_NUMBER,
  input wire logic ACTIVE_CLR,
  output logic [MAP_W-1:0] PARAM_RDATA,
  output logic TX_VALID,
  output logic [NUM_STAT-1:0] TX_STATUS,
  output logic DISP_VALID,
  output logic [NUM_STAT-1:0] DISP_STATUS,
  output logic [NUM_W-1:0] OUT_NUMBER,
  output logic [NUM_STAT-1:0] ACTIVE_STATUS
);
  fdsm_cls_if cif ();

  logic [MAP_W-1:0] failure_category_map_reg;
  logic [MAP_W-1:0] function_check_category_map_reg;
  logic [MAP_W-1:0] out_of_spec_category_map_reg;
  logic [MAP_W-1:0] maintenance_category_map_reg;
  logic [PRI_W-1:0] failure_priority_reg;
  logic [PRI_W-1:0] function_check_priority_reg;
  logic [PRI_W-1:0] out_of_spec_priority_reg;
  logic [PRI_W-1:0] maintenance_priority_reg;
  logic [MAP_W-1:0] bcast_mask_reg;
  logic [NUM_W-1:0] slot_num_reg [1:NUM_SLOT];
  logic [NUM_SLOT:1] slot_en_reg;

  logic [MAP_W-1:0] map_w [NUM_STAT];
  logic [PRI_W-1:0] pri_w [NUM_STAT];
  logic [MAP_W-1:0] cat;
  logic [NUM_STAT-1:0] hit;
  logic [NUM_STAT-1:0] show_next;
  logic [NUM_STAT-1:0] send_next;
  logic map_wr_ok;
  logic [MAP_W-1:0] rdata_next;
  logic [NUM_STAT-1:0] active_next;
  logic [3:0] slot_idx;

  // True when a status at this priority produces any effect
  function automatic logic pri_shows(input logic [PRI_W-1:0] p);
    return p >= PRI_SHOW;
  endfunction

  function automatic logic pri_sends(input logic [PRI_W-1:0] p);
    return p >= PRI_SEND_MIN;
  endfunction

  function automatic logic sel_is(input logic wr, input logic [SEL_W-1:0] sel,
                                  input logic [SEL_W-1:0] code);
    return wr && (sel == code);
  endfunction

  assign map_w[ST_FAIL] = failure_category_map_reg;
  assign map_w[ST_CHECK] = function_check_category_map_reg;
  assign map_w[ST_OFFSPEC] = out_of_spec_category_map_reg;
  assign map_w[ST_MAINT] = maintenance_category_map_reg;
  assign pri_w[ST_FAIL] = failure_priority_reg;
  assign pri_w[ST_CHECK] = function_check_priority_reg;
  assign pri_w[ST_OFFSPEC] = out_of_spec_priority_reg;
  assign pri_w[ST_MAINT] = maintenance_priority_reg;

  assign cif.evt_native = EVT_NATIVE;
  assign cif.evt_number = EVT_NUMBER;
  assign cif.slot_en = slot_en_reg;
  assign cat = cif.cat_bits;
  generate
    for (genvar k = 1; k <= NUM_SLOT; k++) begin : g_slot
      assign cif.slot_num[k] = slot_num_reg[k];
    end
  endgenerate

  fdsm_classify u_classify (
    .cif(cif.cls)
  );

  // Maps are only editable with the block out of service
  assign map_wr_ok = OUT_OF_SERVICE_MODE;

  // One write enable per map, priority and mask, one shared by all slots, decoded from the strobe and select
  logic slot_sel;
  logic fail_map_we;
  logic check_map_we;
  logic offspec_map_we;
  logic maint_map_we;
  logic fail_pri_we;
  logic check_pri_we;
  logic offspec_pri_we;
  logic maint_pri_we;
  logic mask_we;
  logic slot_we;
  logic [NUM_STAT-1:0] masked;

  // Map enables are gated by the out-of-service input
  assign slot_sel = (PARAM_SEL >= SEL_SLOT_FIRST);
  assign fail_map_we = map_wr_ok && sel_is(PARAM_WR, PARAM_SEL, SEL_FAIL_MAP);
  assign check_map_we = map_wr_ok && sel_is(PARAM_WR, PARAM_SEL, SEL_CHECK_MAP);
  assign offspec_map_we = map_wr_ok && sel_is(PARAM_WR, PARAM_SEL, SEL_OFFSPEC_MAP);
  assign maint_map_we = map_wr_ok && sel_is(PARAM_WR, PARAM_SEL, SEL_MAINT_MAP);
  assign fail_pri_we = sel_is(PARAM_WR, PARAM_SEL, SEL_FAIL_PRI);
  assign check_pri_we = sel_is(PARAM_WR, PARAM_SEL, SEL_CHECK_PRI);
  assign offspec_pri_we = sel_is(PARAM_WR, PARAM_SEL, SEL_OFFSPEC_PRI);
  assign maint_pri_we = sel_is(PARAM_WR, PARAM_SEL, SEL_MAINT_PRI);
  assign mask_we = sel_is(PARAM_WR, PARAM_SEL, SEL_BCAST_MASK);
  assign slot_we = PARAM_WR && slot_sel;

  // Routing is resolved against the maps at the moment the event arrives
  generate
    for (genvar s = 0; s < NUM_STAT; s++) begin : g_route
      assign hit[s] = |(map_w[s] & cat);
      assign show_next[s] = EVT_VALID && hit[s] && pri_shows(pri_w[s]);
      assign masked[s] = |(map_w[s] & cat & bcast_mask_reg);
      assign send_next[s] = show_next[s] && pri_sends(pri_w[s]) && !masked[s];
    end
  endgenerate

  // Set wins over clear for the active entries
  assign active_next = (ACTIVE_CLR ? '0 : ACTIVE_STATUS) | show_next;

  // Select codes 11 to 1F address slots 1 to 15
  assign slot_idx = 4'(PARAM_SEL - SEL_SLOT_FIRST + 5'h01);

  // Readback source, registered into the output one cycle later
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (PARAM_SEL)
      SEL_FAIL_MAP: rdata_next = failure_category_map_reg;
      SEL_CHECK_MAP: rdata_next = function_check_category_map_reg;
      SEL_OFFSPEC_MAP: rdata_next = out_of_spec_category_map_reg;
      SEL_MAINT_MAP: rdata_next = maintenance_category_map_reg;
      SEL_FAIL_PRI: rdata_next = {28'h0, failure_priority_reg};
      SEL_CHECK_PRI: rdata_next = {28'h0, function_check_priority_reg};
      SEL_OFFSPEC_PRI: rdata_next = {28'h0, out_of_spec_priority_reg};
      SEL_MAINT_PRI: rdata_next = {28'h0, maintenance_priority_reg};
      SEL_BCAST_MASK: rdata_next = bcast_mask_reg;
      default: begin
        if (slot_sel) begin
          rdata_next[SLOT_EN_BIT] = slot_en_reg[slot_idx];
          rdata_next[NUM_W-1:0] = slot_num_reg[slot_idx];
        end
      end
    endcase
  end

  // Category maps, editable only out of service
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      failure_category_map_reg <= FAIL_MAP_RST;
    end else if (fail_map_we) begin
      failure_category_map_reg <= PARAM_WDATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      function_check_category_map_reg <= CHECK_MAP_RST;
    end else if (check_map_we) begin
      function_check_category_map_reg <= PARAM_WDATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      out_of_spec_category_map_reg <= OFFSPEC_MAP_RST;
    end else if (offspec_map_we) begin
      out_of_spec_category_map_reg <= PARAM_WDATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      maintenance_category_map_reg <= MAINT_MAP_RST;
    end else if (maint_map_we) begin
      maintenance_category_map_reg <= PARAM_WDATA;
    end
  end

  // Priorities and broadcast mask, writable at any time
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      failure_priority_reg <= PRI_RST;
    end else if (fail_pri_we) begin
      failure_priority_reg <= PARAM_WDATA[PRI_W-1:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      function_check_priority_reg <= PRI_RST;
    end else if (check_pri_we) begin
      function_check_priority_reg <= PARAM_WDATA[PRI_W-1:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      out_of_spec_priority_reg <= PRI_RST;
    end else if (offspec_pri_we) begin
      out_of_spec_priority_reg <= PARAM_WDATA[PRI_W-1:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      maintenance_priority_reg <= PRI_RST;
    end else if (maint_pri_we) begin
      maintenance_priority_reg <= PARAM_WDATA[PRI_W-1:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      bcast_mask_reg <= MASK_RST;
    end else if (mask_we) begin
      bcast_mask_reg <= PARAM_WDATA;
    end
  end

  // Configurable slots: enable bit and bound diagnostic number
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      slot_en_reg <= '0;
    end else if (slot_we) begin
      slot_en_reg[slot_idx] <= PARAM_WDATA[SLOT_EN_BIT];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      for (int k = 1; k <= NUM_SLOT; k++) slot_num_reg[k] <= '0;
    end else if (slot_we) begin
      slot_num_reg[slot_idx] <= PARAM_WDATA[NUM_W-1:0];
    end
  end

  // Event results: send and show pulse one cycle, number and active set hold
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      TX_VALID <= 1'b0;
    end else begin
      TX_VALID <= |send_next;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      TX_STATUS <= '0;
    end else begin
      TX_STATUS <= send_next;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      DISP_VALID <= 1'b0;
    end else begin
      DISP_VALID <= |show_next;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      DISP_STATUS <= '0;
    end else begin
      DISP_STATUS <= show_next;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      OUT_NUMBER <= '0;
    end else if (EVT_VALID) begin
      OUT_NUMBER <= EVT_NUMBER;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ACTIVE_STATUS <= '0;
    end else begin
      ACTIVE_STATUS <= active_next;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      PARAM_RDATA <= 32'h0000_0000;
    end else begin
      PARAM_RDATA <= rdata_next;
    end
  end
endmodule // fdsm_top
`default_nettype wire

// ### sim/fdsm_host_model.sv
// Fieldbus host model counting the alarms that reach the bus
`timescale 1ns/1ps
`default_nettype none
module fdsm_host_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tx_valid,
  input wire logic [3:0] tx_status,
  output var int rx_count
);
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_count <= 0;
    end else if (tx_valid && (|tx_status)) begin
      rx_count <= rx_count + 1;
    end
  end
endmodule // fdsm_host_model
`default_nettype wire

// ### sim/fdsm_top_sva.sv
// Assertion checker for the diagnostic status mapper top ports
`timescale 1ns/1ps
`default_nettype none
module fdsm_chk
  import fdsm_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic PARAM_WR,
  input wire logic [SEL_W-1:0] PARAM_SEL,
  input wire logic EVT_VALID,
  input wire logic [NUM_W-1:0] EVT_NUMBER,
  input wire logic ACTIVE_CLR,
  input wire logic [MAP_W-1:0] PARAM_RDATA,
  input wire logic TX_VALID,
  input wire logic [NUM_STAT-1:0] TX_STATUS,
  input wire logic DISP_VALID,
  input wire logic [NUM_STAT-1:0] DISP_STATUS,
  input wire logic [NUM_W-1:0] OUT_NUMBER,
  input wire logic [NUM_STAT-1:0] ACTIVE_STATUS
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  only_on_event_a: assert property ((TX_VALID || DISP_VALID) |-> $past(EVT_VALID))
    else $error("status pulse without an event");
  sent_is_shown_a: assert property ((TX_STATUS & ~DISP_STATUS) == 4'h0)
    else $error("status sent but not shown");
  tx_flag_a: assert property (TX_VALID == (|TX_STATUS))
    else $error("send flag disagrees with send status");
  disp_flag_a: assert property (DISP_VALID == (|DISP_STATUS))
    else $error("show flag disagrees with show status");
  number_capture_a: assert property ($past(EVT_VALID) |-> OUT_NUMBER == $past(EVT_NUMBER))
    else $error("event number not captured");
  number_hold_a: assert property (!$past(EVT_VALID) && !$past(SYS_RST) |-> $stable(OUT_NUMBER))
    else $error("event number changed without event");
  active_track_a: assert property (ACTIVE_STATUS ==
    (($past(ACTIVE_CLR) ? 4'h0 : $past(ACTIVE_STATUS)) | DISP_STATUS))
    else $error("active status not sticky");
  reset_quiet_a: assert property ($past(SYS_RST) |-> !TX_VALID && !DISP_VALID && !ACTIVE_STATUS)
    else $error("outputs not quiet after reset");
  readback_steady_a: assert property (!$past(SYS_RST) && !$past(SYS_RST, 2)
    && !$past(PARAM_WR, 2) && $past(PARAM_SEL) == $past(PARAM_SEL, 2) |-> $stable(PARAM_RDATA))
    else $error("readback changed without write");
  cover property (TX_VALID);
  cover property (DISP_VALID && !TX_VALID);
  cover property (EVT_VALID && ACTIVE_CLR);
endmodule // fdsm_chk
bind fdsm_top fdsm_chk chk (.MCLK, .SYS_RST, .PARAM_WR, .PARAM_SEL, .EVT_VALID, .EVT_NUMBER,
  .ACTIVE_CLR, .PARAM_RDATA, .TX_VALID, .TX_STATUS, .DISP_VALID, .DISP_STATUS, .OUT_NUMBER,
  .ACTIVE_STATUS);
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the diagnostic status mapper
`timescale 1ns/1ps
`default_nettype none
module tb
  import fdsm_pkg::*;
;
  logic MCLK, SYS_RST, OUT_OF_SERVICE_MODE, PARAM_WR, EVT_VALID, ACTIVE_CLR, TX_VALID;
  logic DISP_VALID, evt_d;
  logic [SEL_W-1:0] PARAM_SEL;
  logic [MAP_W-1:0] PARAM_WDATA, PARAM_RDATA, msk, r;
  logic [1:0] EVT_NATIVE;
  logic [NUM_W-1:0] EVT_NUMBER, OUT_NUMBER;
  logic [NUM_STAT-1:0] TX_STATUS, DISP_STATUS, ACTIVE_STATUS, act;
  logic [MAP_W-1:0] mp [NUM_STAT];
  logic [PRI_W-1:0] pr [NUM_STAT];
  logic [NUM_W-1:0] sn [1:NUM_SLOT];
  logic [NUM_SLOT:1] se;
  logic [31:0] q [$];
  int fail_count, n_tests, txc, rx_count, seed;
  wire logic [31:0] seen = {8'h00, TX_VALID, DISP_VALID, TX_STATUS, DISP_STATUS, ACTIVE_STATUS,
    OUT_NUMBER};
  fdsm_top dut (.MCLK, .SYS_RST, .OUT_OF_SERVICE_MODE, .PARAM_WR, .PARAM_SEL, .PARAM_WDATA,
    .EVT_VALID, .EVT_NATIVE, .EVT_NUMBER, .ACTIVE_CLR, .PARAM_RDATA, .TX_VALID, .TX_STATUS,
    .DISP_VALID, .DISP_STATUS, .OUT_NUMBER, .ACTIVE_STATUS);
  fdsm_host_model host (.mclk(MCLK), .rst(SYS_RST), .tx_valid(TX_VALID), .tx_status(TX_STATUS),
    .rx_count(rx_count));
  task automatic final_report;
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge MCLK);
    #1;
  endtask
  function automatic logic [31:0] expv(input int s);
    if (s < 4) return mp[s];
    if (s < 8) return {28'h0, pr[s-4]};
    if (s >= 17) return {16'h0, se[s-16], 5'h00, sn[s-16]};
    return (s == 8) ? msk : 32'h0;
  endfunction
  // Expected send and show bits, worked out from the shadow settings
  function automatic logic [7:0] route(input logic [1:0] nat, input logic [9:0] n);
    logic [31:0] c;
    logic [3:0] tx, ds;
    int a;
    c = 32'h0;
    a = n <= 199 ? 0 : n <= 399 ? 1 : n <= 700 ? 2 : (n >= 800 && n <= 999) ? 3 : 4;
    if (a < 4) c[31 - 4 * nat - a] = 1'b1;
    for (int k = 1; k <= 15; k++) if (se[k] && sn[k] == n) c[k] = 1'b1;
    for (int s = 0; s < 4; s++) begin
      ds[s] = (|(mp[s] & c)) && pr[s] != 4'h0;
      tx[s] = ds[s] && pr[s] >= 4'h2 && !(|(mp[s] & c & msk));
    end
    return {tx, ds};
  endfunction
  task automatic rd(input int s);
    PARAM_WR = 1'b0;
    EVT_VALID = 1'b0;
    ACTIVE_CLR = 1'b0;
    PARAM_SEL = s[4:0];
    step();
    chk(PARAM_RDATA, expv(s));
  endtask
  task automatic wr(input int s, input logic [31:0] d);
    EVT_VALID = 1'b0;
    ACTIVE_CLR = 1'b0;
    PARAM_WR = 1'b1;
    PARAM_SEL = s[4:0];
    PARAM_WDATA = d;
    if (s < 4 && OUT_OF_SERVICE_MODE) mp[s] = d;
    else if (s >= 4 && s < 8) pr[s-4] = d[3:0];
    else if (s == 8) msk = d;
    else if (s >= 17) begin
      se[s-16] = d[15];
      sn[s-16] = d[9:0];
    end
    step();
    rd(s);
  endtask
  task automatic ev(input logic [1:0] nat, input logic [9:0] n, input logic clr);
    logic [7:0] e;
    EVT_VALID = 1'b1;
    EVT_NATIVE = nat;
    EVT_NUMBER = n;
    ACTIVE_CLR = clr;
    e = route(nat, n);
    act = (clr ? 4'h0 : act) | e[3:0];
    txc += (|e[7:4]) ? 1 : 0;
    q.push_back({8'h00, |e[7:4], |e[3:0], e, act, n});
    step();
  endtask
  always @(posedge MCLK) evt_d <= EVT_VALID & ~SYS_RST;
  always @(negedge MCLK) begin
    if (evt_d && q.size() == 0) chk(seen, 32'h0);
    else if (evt_d) chk(seen, q.pop_front());
  end
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  initial begin
    #100000;
    fail_count++;
    final_report();
  end
  initial begin
    {SYS_RST, OUT_OF_SERVICE_MODE, PARAM_WR, EVT_VALID, ACTIVE_CLR} = 5'h10;
    {PARAM_SEL, PARAM_WDATA, EVT_NATIVE, EVT_NUMBER, msk, act, se} = '0;
    mp = '{FAIL_MAP_RST, CHECK_MAP_RST, OFFSPEC_MAP_RST, MAINT_MAP_RST};
    pr = '{4'h0, 4'h0, 4'h0, 4'h0};
    sn = '{default: 10'h000};
    seed = 32'h96FB769C;
    repeat (16) @(posedge MCLK);
    #1;
    SYS_RST = 1'b0;
    for (int s = 0; s < 32; s++) rd(s);
    ev(2'h0, 10'h0FA, 1'b0);
    wr(4, 32'h0000_0002);
    ev(2'h0, 10'h0FA, 1'b0);
    repeat (600) begin
      r = $random(seed);
      OUT_OF_SERVICE_MODE = (r[2:0] == 3'h5) && r[3];
      case (r[2:0])
        3'h4: wr(4 + r[4:3], {28'h0, r[11:8]});
        3'h5: wr(r[5:4], $random(seed) | (FAIL_MAP_RST >> (4 * r[5:4])));
        3'h6: wr(8, $random(seed) & $random(seed));
        3'h7: wr(17 + r[6:3] % 15, {16'h0, r[7], 5'h00, r[25:16]});
        default: ev(r[4:3], r[5] ? sn[r[9:6] % 15 + 1] : r[25:16], r[28] & r[29]);
      endcase
    end
    rd(8);
    repeat (3) step();
    chk(rx_count, txc);
    final_report();
  end
endmodule // tb
`default_nettype wire
